/* hw/acsi_defines.vh */
// Shared constants of the asynchronous serial interface.
`ifndef ACSI_DEFINES_VH
`define ACSI_DEFINES_VH

// ----------------------------------------------------------------
// Prescaler divisors selected by the two prescale bits
// ----------------------------------------------------------------
`define ACSI_PRE_DIV0     4'h1
`define ACSI_PRE_DIV1     4'h3
`define ACSI_PRE_DIV2     4'h4
`define ACSI_PRE_DIV3     4'hD

// ----------------------------------------------------------------
// Sample ticks; a count value k stands for sample tick k+1
// ----------------------------------------------------------------
`define ACSI_RT_LAST      4'hF
`define ACSI_RT_VER1      4'h2
`define ACSI_RT_VER2      4'h4
`define ACSI_RT_VER3      4'h6
`define ACSI_RT_SMP1      4'h7
`define ACSI_RT_SMP2      4'h8
`define ACSI_RT_SMP3      4'h9
`define ACSI_RT_HALF      4'h8

// ----------------------------------------------------------------
// Frame lengths in bits and idle line lengths in sample ticks
// ----------------------------------------------------------------
`define ACSI_FRAME8       4'hA
`define ACSI_FRAME9       4'hB
`define ACSI_IDLE_RT8     8'hA0
`define ACSI_IDLE_RT9     8'hB0

// ----------------------------------------------------------------
// Reset values of the flags
// ----------------------------------------------------------------
`define ACSI_RST_TX_BUFFER_EMPTY_FLAG     1'b1
`define ACSI_RST_TC       1'b1
`define ACSI_RST_ERR      1'b0

`endif

/* hw/acsi_sync.v */
// Two-flop synchroniser for the receive data pin.
`timescale 1ns/1ps
`default_nettype none

module acsi_sync (
  input  wire clk_i,   // Bus clock.
  input  wire rstn_i,  // Asynchronous reset, active low.
  input  wire d_i,     // Asynchronous pin level.
  output reg  q_o      // Synchronised level.
);

  reg meta_q;

  // The idle line is high, so both stages reset high to avoid a false start.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // acsi_sync

`default_nettype wire

/* hw/acsi_rate_gen.v */
// Binary rate selector: divides the prescaled tick by two to the power of the select.
`timescale 1ns/1ps
`default_nettype none

module acsi_rate_gen #(
  parameter SEL_W = 3
) (
  input  wire             clk_i,   // Bus clock.
  input  wire             rstn_i,  // Asynchronous reset, active low.
  input  wire             tick_i,  // Prescaled tick, one cycle.
  input  wire [SEL_W-1:0] sel_i,   // Rate select.
  output reg              tick_o   // Divided tick, one cycle.
);

  reg  [7:0] cnt_q;
  wire [7:0] lim = (8'h01 << sel_i) - 8'h01;

  // Each selector runs on its own counter so the two directions stay independent.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (cnt_q >= lim) begin
          cnt_q  <= 8'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // acsi_rate_gen

`default_nettype wire

/* hw/acsi_serial.v */
// Full-duplex asynchronous serial interface with synchronous transmit clock.
`timescale 1ns/1ps
`default_nettype none
`include "acsi_defines.vh"

// Operation
// - NRZ frames, start, 8/9 data, stop.
// - Transmit clock only on data bits, optional last.
// - Transmit clock phase and polarity selectable.
// - Disagreeing samples report noise.
// - 32 rates, receive rate independent.
// - Wake method and word length bits.
// - Enables, interrupt enables, sleep, break bits.
// - Data write loads buffer, clears buffer-empty.
// - Load on bit clock, least bit first.
// - Complete flag when nothing pending.
// - Disabled after send also sets complete.
// - Disable finishes current character first.
// - Data read returns received byte if enabled.
// - Received byte transfer sets full flag.
// - Separate overrun, noise, framing flags.
// - Idle flag with enable raises interrupt.
// - Idle only after a received character.
// - Two-bit prescaler feeds two 3-bit selectors.
// - Fixed divide-by-16 before the transmitter.
// - Transmitter and receiver run independently.
// - Sleep inhibits receive flags and idle.
// - Sixteen-times sampling, majority of three.
// - Break is one whole frame of zeros.
// - Disabled transmitter releases data and clock.
module acsi_serial (
  input  wire       clk_i,                    // Bus clock, 40 MHz.
  input  wire       rstn_i,                   // Asynchronous reset, active low.
  input  wire       wake_method_i,            // 0 idle line wake, 1 address mark wake.
  input  wire       word_length_i,            // 0 eight, 1 nine data bits.
  input  wire       last_bit_clock_enable_i,  // Clock pulse on the last data bit.
  input  wire       tx_clock_polarity_i,      // Idle level of the transmit clock.
  input  wire       tx_clock_phase_i,         // Pulse in the first half of a bit.
  input  wire       tx_enable_bit_i,          // Transmitter enable.
  input  wire       rx_enable_bit_i,          // Receiver enable.
  input  wire       send_break_bit_i,         // Send break frames.
  input  wire       tx_empty_irq_en_i,        // Buffer-empty interrupt enable.
  input  wire       tx_complete_irq_en_i,     // Complete interrupt enable.
  input  wire       rx_irq_en_i,              // Receive interrupt enable.
  input  wire       idle_irq_en_i,            // Idle line interrupt enable.
  input  wire       sleep_set_i,              // Pulse: enter receiver sleep.
  input  wire       sleep_clr_i,              // Pulse: leave receiver sleep.
  input  wire [1:0] prescale_i,               // Shared prescaler select.
  input  wire [2:0] rx_rate_select_i,         // Receive rate select.
  input  wire [2:0] tx_rate_select_i,         // Transmit rate select.
  input  wire       data_write_i,             // Pulse: write to the data register.
  input  wire [7:0] data_wdata_i,             // Written byte.
  input  wire       tx_bit8_i,                // Ninth transmit bit.
  input  wire       data_read_i,              // Pulse: read of the data register.
  input  wire       rx_data_input_i,          // Receive pin.
  output reg  [7:0] data_rdata_o,             // Received byte, zero while disabled.
  output reg        rx_bit8_o,                // Ninth received bit.
  output reg        tx_buffer_empty_flag_o,   // Transmit buffer empty.
  output reg        tx_complete_flag_o,       // Transmission complete.
  output reg        rx_full_flag_o,           // Receive data full.
  output reg        idle_flag_o,              // Idle line seen.
  output reg        overrun_flag_o,           // Overrun.
  output reg        noise_flag_o,             // Noise.
  output reg        framing_error_flag_o,     // Framing error.
  output reg        receiver_sleep_bit_o,     // Receiver asleep.
  output reg        tx_irq_o,                 // Transmit interrupt request.
  output reg        rx_irq_o,                 // Receive interrupt request.
  output reg        tx_data_o,                // Transmit pin level.
  output reg        tx_data_oe_o,             // Transmit pin driven.
  output reg        tx_clock_o,               // Transmit clock pin level.
  output reg        tx_clock_oe_o             // Transmit clock pin driven.
);

  localparam TXK_DATA  = 2'b00;
  localparam TXK_PRE   = 2'b01;
  localparam TXK_BREAK = 2'b10;
  localparam RX_IDLE   = 1'b0;
  localparam RX_FRAME  = 1'b1;

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  function [3:0] acsi_pre_div;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   acsi_pre_div = `ACSI_PRE_DIV0;
        2'b01:   acsi_pre_div = `ACSI_PRE_DIV1;
        2'b10:   acsi_pre_div = `ACSI_PRE_DIV2;
        default: acsi_pre_div = `ACSI_PRE_DIV3;
      endcase
    end
  endfunction

  reg [3:0] pre_cnt_q;
  reg       pre_tick_q;
  wire      tx_rt_tick;
  wire      rx_rt_tick;
  wire      rxs;

  // Rate changes while enabled give one odd period; software avoids them.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt_q  <= 4'h0;
      pre_tick_q <= 1'b0;
    end else if (pre_cnt_q >= acsi_pre_div(prescale_i) - 4'h1) begin
      pre_cnt_q  <= 4'h0;
      pre_tick_q <= 1'b1;
    end else begin
      pre_cnt_q  <= pre_cnt_q + 4'h1;
      pre_tick_q <= 1'b0;
    end
  end

  // Each direction has its own selector behind the one prescaler.
  acsi_rate_gen #(.SEL_W(3)) u_tx_rate (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_i (pre_tick_q),
    .sel_i  (tx_rate_select_i),
    .tick_o (tx_rt_tick)
  );

  acsi_rate_gen #(.SEL_W(3)) u_rx_rate (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_i (pre_tick_q),
    .sel_i  (rx_rate_select_i),
    .tick_o (rx_rt_tick)
  );

  acsi_sync u_rx_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (rx_data_input_i),
    .q_o    (rxs)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg  [3:0]  tx_div_q;
  reg  [10:0] tx_shift_q;
  reg  [3:0]  tx_cnt_q;
  reg  [1:0]  tx_kind_q;
  reg  [7:0]  tx_buf_q;
  reg         tx_buf8_q;
  reg         te_prev_q;
  reg         pre_pend_q;
  wire [3:0]  tx_flen = word_length_i ? `ACSI_FRAME9 : `ACSI_FRAME8;
  wire        tx_bit_tick = tx_rt_tick && (tx_div_q == `ACSI_RT_LAST);
  wire        tx_busy = (tx_cnt_q != 4'h0);
  wire        tx_is_data = tx_busy && (tx_kind_q == TXK_DATA) &&
                           (tx_cnt_q != tx_flen) && (tx_cnt_q != 4'h1);
  wire        tx_clk_on = tx_is_data &&
                          ((tx_cnt_q != 4'h2) || last_bit_clock_enable_i);
  // A write in the same cycle as a load waits one bit so no byte is lost.
  wire        tx_can_load = tx_enable_bit_i && !tx_buffer_empty_flag_o && !data_write_i;

  // Divide-by-16 keeps equal selects giving equal rates on both sides.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_div_q <= 4'h0;
    end else if (tx_rt_tick) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  // Frame sequencer: loads happen only on a bit boundary.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_shift_q             <= 11'h7FF;
      tx_cnt_q               <= 4'h0;
      tx_kind_q              <= TXK_DATA;
      tx_buf_q               <= 8'h00;
      tx_buf8_q              <= 1'b0;
      te_prev_q              <= 1'b0;
      pre_pend_q             <= 1'b0;
      tx_buffer_empty_flag_o <= `ACSI_RST_TX_BUFFER_EMPTY_FLAG;
      tx_complete_flag_o     <= `ACSI_RST_TC;
    end else begin
      te_prev_q <= tx_enable_bit_i;
      if (tx_enable_bit_i && !te_prev_q) begin
        pre_pend_q <= 1'b1;
      end
      if (data_write_i) begin
        tx_buf_q               <= data_wdata_i;
        tx_buf8_q              <= tx_bit8_i;
        tx_buffer_empty_flag_o <= 1'b0;
        tx_complete_flag_o     <= 1'b0;
      end
      if (tx_bit_tick) begin
        if (tx_cnt_q > 4'h1) begin
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_cnt_q   <= tx_cnt_q - 4'h1;
        end else if (tx_can_load) begin
          // Start, data least bit first, optional ninth bit, stop.
          tx_shift_q <= word_length_i ? {1'b1, tx_buf8_q, tx_buf_q, 1'b0}
                                      : {2'b11, tx_buf_q, 1'b0};
          tx_cnt_q               <= tx_flen;
          tx_kind_q              <= TXK_DATA;
          tx_buffer_empty_flag_o <= 1'b1;
          tx_complete_flag_o     <= 1'b0;
        end else if (tx_enable_bit_i && pre_pend_q) begin
          tx_shift_q         <= 11'h7FF;
          tx_cnt_q           <= tx_flen;
          tx_kind_q          <= TXK_PRE;
          pre_pend_q         <= 1'b0;
          tx_complete_flag_o <= 1'b0;
        end else if (tx_enable_bit_i && send_break_bit_i) begin
          tx_shift_q         <= 11'h000;
          tx_cnt_q           <= tx_flen;
          tx_kind_q          <= TXK_BREAK;
          tx_complete_flag_o <= 1'b0;
        end else begin
          // Nothing pending, or disabled after the last frame went out.
          tx_cnt_q <= 4'h0;
          if (tx_busy && !data_write_i) begin
            tx_complete_flag_o <= 1'b1;
          end
        end
      end
    end
  end

  // Pins stay driven until the frame in flight is out, then float.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_data_o     <= 1'b1;
      tx_data_oe_o  <= 1'b0;
      tx_clock_o    <= 1'b0;
      tx_clock_oe_o <= 1'b0;
    end else begin
      tx_data_o     <= tx_busy ? tx_shift_q[0] : 1'b1;
      tx_data_oe_o  <= tx_enable_bit_i || tx_busy;
      tx_clock_oe_o <= tx_enable_bit_i || tx_busy;
      tx_clock_o    <= tx_clock_polarity_i ^
                       (tx_clk_on && (tx_div_q[3] ^ tx_clock_phase_i));
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  reg        rx_state_q;
  reg  [3:0] rx_rt_q;
  reg  [3:0] rx_bit_q;
  reg  [2:0] rx_smp_q;
  reg  [1:0] rx_ver_q;
  reg  [8:0] rx_shift_q;
  reg        rx_frm_noise_q;
  reg        rx_wait_high_q;
  reg        rx_seen_q;
  reg  [7:0] rx_idle_cnt_q;
  reg  [7:0] rx_buf_q;
  wire [3:0] rx_rt_nx = rx_rt_q + 4'h1;
  wire [3:0] rx_flen = word_length_i ? `ACSI_FRAME9 : `ACSI_FRAME8;
  wire [7:0] rx_idle_len = word_length_i ? `ACSI_IDLE_RT9 : `ACSI_IDLE_RT8;
  wire [2:0] rx_smp_all = {rx_smp_q[1:0], rxs};
  wire       rx_vote = (rx_smp_all[0] & rx_smp_all[1]) | (rx_smp_all[0] & rx_smp_all[2]) |
                       (rx_smp_all[1] & rx_smp_all[2]);
  wire       rx_disagree = (rx_smp_all != 3'b000) && (rx_smp_all != 3'b111);
  wire       rx_stop_bit = (rx_bit_q == rx_flen - 4'h1);
  wire [7:0] rx_data_nx = word_length_i ? rx_shift_q[7:0] : rx_shift_q[8:1];
  wire       rx_msb_nx = word_length_i ? rx_shift_q[8] : rx_shift_q[8];
  wire       rx_break = (rx_shift_q == 9'h000) && !rx_vote;
  wire       rx_idle_hit = (rx_idle_cnt_q == rx_idle_len - 8'h01) && rx_rt_tick && rxs;

  // Bit timing, voting and the end-of-frame flag updates.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_q           <= RX_IDLE;
      rx_rt_q              <= 4'h0;
      rx_bit_q             <= 4'h0;
      rx_smp_q             <= 3'b111;
      rx_ver_q             <= 2'b00;
      rx_shift_q           <= 9'h000;
      rx_frm_noise_q       <= 1'b0;
      rx_wait_high_q       <= 1'b0;
      rx_seen_q            <= 1'b0;
      rx_idle_cnt_q        <= 8'h00;
      rx_buf_q             <= 8'h00;
      rx_bit8_o            <= 1'b0;
      rx_full_flag_o       <= 1'b0;
      idle_flag_o          <= 1'b0;
      overrun_flag_o       <= `ACSI_RST_ERR;
      noise_flag_o         <= `ACSI_RST_ERR;
      framing_error_flag_o <= `ACSI_RST_ERR;
      receiver_sleep_bit_o <= 1'b0;
    end else begin
      // Clears come first so that a set in the same cycle wins.
      if (data_read_i) begin
        rx_full_flag_o       <= 1'b0;
        idle_flag_o          <= 1'b0;
        overrun_flag_o       <= 1'b0;
        noise_flag_o         <= 1'b0;
        framing_error_flag_o <= 1'b0;
      end
      if (sleep_clr_i) begin
        receiver_sleep_bit_o <= 1'b0;
      end
      if (sleep_set_i) begin
        receiver_sleep_bit_o <= 1'b1;
      end
      // Idle line counter runs only while the receiver waits for a start.
      if (!rx_enable_bit_i || rx_state_q == RX_FRAME || !rxs) begin
        rx_idle_cnt_q <= 8'h00;
      end else if (rx_rt_tick && !rx_idle_hit) begin
        rx_idle_cnt_q <= rx_idle_cnt_q + 8'h01;
      end
      if (rx_idle_hit) begin
        rx_idle_cnt_q <= 8'h00;
        if (receiver_sleep_bit_o && !wake_method_i) begin
          receiver_sleep_bit_o <= 1'b0;
        end else if (!receiver_sleep_bit_o && rx_seen_q) begin
          idle_flag_o <= 1'b1;
          rx_seen_q   <= 1'b0;
        end
      end
      if (!rx_enable_bit_i) begin
        rx_state_q <= RX_IDLE;
      end else if (rx_rt_tick) begin
        case (rx_state_q)
          RX_IDLE: begin
            if (rxs) begin
              rx_wait_high_q <= 1'b0;
            end else if (!rx_wait_high_q) begin
              // This tick is the first sample of a possible start bit.
              rx_state_q     <= RX_FRAME;
              rx_rt_q        <= 4'h0;
              rx_bit_q       <= 4'h0;
              rx_ver_q       <= 2'b00;
              rx_frm_noise_q <= 1'b0;
            end
          end
          default: begin
            rx_rt_q  <= rx_rt_nx;
            rx_smp_q <= rx_smp_all;
            if (rx_bit_q == 4'h0 && (rx_rt_nx == `ACSI_RT_VER1 ||
                rx_rt_nx == `ACSI_RT_VER2 || rx_rt_nx == `ACSI_RT_VER3)) begin
              if (rxs) begin
                rx_frm_noise_q <= 1'b1;
                rx_ver_q       <= rx_ver_q + 2'b01;
                if (rx_ver_q != 2'b00) begin
                  rx_state_q <= RX_IDLE;
                end
              end
            end
            if (rx_rt_nx == `ACSI_RT_SMP3) begin
              if (rx_disagree) begin
                rx_frm_noise_q <= 1'b1;
              end
              if (rx_bit_q != 4'h0 && !rx_stop_bit) begin
                rx_shift_q <= {rx_vote, rx_shift_q[8:1]};
              end
              if (rx_stop_bit) begin
                rx_state_q     <= RX_IDLE;
                rx_wait_high_q <= rx_break;
                if (!receiver_sleep_bit_o || (wake_method_i && rx_msb_nx)) begin
                  receiver_sleep_bit_o <= 1'b0;
                  rx_seen_q            <= 1'b1;
                  if (rx_full_flag_o && !data_read_i) begin
                    overrun_flag_o <= 1'b1;
                  end else begin
                    rx_buf_q             <= rx_data_nx;
                    rx_bit8_o            <= rx_shift_q[8];
                    rx_full_flag_o       <= 1'b1;
                    noise_flag_o         <= rx_frm_noise_q || rx_disagree;
                    framing_error_flag_o <= !rx_vote;
                  end
                end
              end
            end
            if (rx_rt_nx == `ACSI_RT_LAST) begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Register the read data and the interrupt requests onto their outputs.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_rdata_o <= 8'h00;
      tx_irq_o     <= 1'b0;
      rx_irq_o     <= 1'b0;
    end else begin
      data_rdata_o <= rx_enable_bit_i ? rx_buf_q : 8'h00;
      tx_irq_o     <= (tx_buffer_empty_flag_o && tx_empty_irq_en_i) ||
                      (tx_complete_flag_o && tx_complete_irq_en_i);
      rx_irq_o     <= ((rx_full_flag_o || overrun_flag_o) && rx_irq_en_i) ||
                      (idle_flag_o && idle_irq_en_i);
    end
  end

endmodule // acsi_serial

`default_nettype wire

/* tb/acsi_serial_checker.sv */
// Port checker for the serial interface.
`timescale 1ns/1ps
`default_nettype none
module acsi_serial_checker (
  input wire logic       clk_i, rstn_i,                            // Clock, reset.
  input wire logic       tx_empty_irq_en_i, tx_complete_irq_en_i,  // Tx enables.
  input wire logic       rx_irq_en_i, idle_irq_en_i, wake_method_i, // Rx enables.
  input wire logic       tx_enable_bit_i, rx_enable_bit_i,         // Unit enables.
  input wire logic       data_write_i, data_read_i,                // Data strobes.
  input wire logic       tx_buffer_empty_flag_o, tx_complete_flag_o, // Tx flags.
  input wire logic       rx_full_flag_o, idle_flag_o, overrun_flag_o, // Rx flags.
  input wire logic       noise_flag_o, framing_error_flag_o,       // Error flags.
  input wire logic       receiver_sleep_bit_o, tx_irq_o, rx_irq_o, // Sleep, irqs.
  input wire logic [7:0] data_rdata_o                              // Read data.
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Interrupt lines are the enabled flags, one cycle late.
  a_tx_irq_lag: assert property (tx_irq_o == $past((tx_buffer_empty_flag_o &
    tx_empty_irq_en_i) | (tx_complete_flag_o & tx_complete_irq_en_i))) else $error("tx irq");
  a_rx_irq_lag: assert property (rx_irq_o == $past(((rx_full_flag_o |
    overrun_flag_o) & rx_irq_en_i) | (idle_flag_o & idle_irq_en_i))) else $error("rx irq");
  a_write_clears: assert property (data_write_i |=>
    !tx_buffer_empty_flag_o && !tx_complete_flag_o) else $error("write clear");
  a_load_needs_te: assert property ($rose(tx_buffer_empty_flag_o) |->
    $past(tx_enable_bit_i)) else $error("load te");
  a_full_needs_re: assert property ($rose(rx_full_flag_o) |->
    $past(rx_enable_bit_i)) else $error("full re");
  a_sleep_blocks: assert property ($rose(rx_full_flag_o) && !wake_method_i |->
    !$past(receiver_sleep_bit_o)) else $error("sleep");
  a_read_clears: assert property (data_read_i |=> rx_full_flag_o ||
    !(overrun_flag_o | noise_flag_o | framing_error_flag_o)) else $error("read clear");
  a_rdata_zero: assert property (!rx_enable_bit_i && !$past(rx_enable_bit_i) |->
    data_rdata_o == 8'h00) else $error("rdata");
  c_overrun: cover property ($rose(overrun_flag_o));
  c_framing: cover property ($rose(framing_error_flag_o));
  c_complete: cover property ($rose(tx_complete_flag_o));
endmodule // acsi_serial_checker
bind acsi_serial acsi_serial_checker u_chk (.clk_i, .rstn_i, .tx_empty_irq_en_i,
  .tx_complete_irq_en_i, .rx_irq_en_i, .idle_irq_en_i, .wake_method_i, .tx_enable_bit_i,
  .rx_enable_bit_i, .data_write_i, .data_read_i, .tx_buffer_empty_flag_o,
  .tx_complete_flag_o, .rx_full_flag_o, .idle_flag_o, .overrun_flag_o, .noise_flag_o,
  .framing_error_flag_o, .receiver_sleep_bit_o, .tx_irq_o, .rx_irq_o, .data_rdata_o);
`default_nettype wire

/* tb/acsi_node.sv */
// Remote serial node driving the receive pin.
`timescale 1ns/1ps
`default_nettype none
module acsi_node #(
  parameter int BIT = 16  // Clocks per bit.
) (
  input  wire logic clk_i,  // Clock.
  output var  logic line_o  // Line level.
);
  // ----------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------
  // The line rests at mark, so a receiver sees a clean start edge.
  initial line_o = 1'b1;
  // Start, n data bits from the bottom, then the chosen stop level.
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    int i;
    line_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (i = 0; i < n; i++) begin
      line_o <= d[i];
      repeat (BIT) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (BIT) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule // acsi_node
`default_nettype wire

/* tb/acsi_serial_tb_top.sv */
// Self-checking bench for the serial interface.
`timescale 1ns/1ps
`default_nettype none
module acsi_serial_tb_top;
  // ----------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------
  logic clk_i = 1'b0, rstn_i = 1'b0, wake_method_i = 1'b0, word_length_i = 1'b0;
  logic last_bit_clock_enable_i = 1'b0, tx_clock_polarity_i = 1'b0, tx_clock_phase_i = 1'b0;
  logic tx_enable_bit_i = 1'b0, rx_enable_bit_i = 1'b0, send_break_bit_i = 1'b0;
  logic tx_empty_irq_en_i = 1'b0, tx_complete_irq_en_i = 1'b0, rx_irq_en_i = 1'b0;
  logic idle_irq_en_i = 1'b0, sleep_set_i = 1'b0, sleep_clr_i = 1'b0, tx_bit8_i = 1'b0;
  logic data_write_i = 1'b0, data_read_i = 1'b0, rx_data_input_i;
  logic [1:0] prescale_i = 2'h0;
  logic [2:0] rx_rate_select_i = 3'h0, tx_rate_select_i = 3'h0;
  logic [7:0] data_wdata_i = 8'h00, data_rdata_o;
  logic rx_bit8_o, tx_buffer_empty_flag_o, tx_complete_flag_o, rx_full_flag_o, idle_flag_o;
  logic overrun_flag_o, noise_flag_o, framing_error_flag_o, receiver_sleep_bit_o;
  logic tx_irq_o, rx_irq_o, tx_data_o, tx_data_oe_o, tx_clock_o, tx_clock_oe_o;
  logic [9:0] f;
  int n_mismatch = 0, n_tests = 0, i;
  acsi_serial dut (.*);
  acsi_node #(.BIT(16)) u_node (.clk_i(clk_i), .line_o(rx_data_input_i));
  // Fastest rate: one bit is sixteen clocks.
  always #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return tx_buffer_empty_flag_o;
      1: return tx_complete_flag_o;
      2: return !tx_data_oe_o;
      default: return !tx_data_o;
    endcase
  endfunction
  // A wait that runs out ends the run, since later checks would be meaningless.
  task automatic wt(input int s);
    int k;
    for (k = 0; k < 4000 && cond(s) !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 4000) begin
      chk("wait", 11'h1, 11'h0);
      results;
    end
  endtask
  task automatic strobe(input int w, input logic [7:0] d);
    @(posedge clk_i);
    data_wdata_i <= d;
    if (w == 1) data_write_i <= 1'b1; else if (w == 0) data_read_i <= 1'b1;
    if (w == 2) sleep_set_i <= 1'b1; else if (w == 3) sleep_clr_i <= 1'b1;
    @(posedge clk_i);
    {data_write_i, data_read_i, sleep_set_i, sleep_clr_i} <= 4'h0;
    #1;
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    @(posedge clk_i);
    #1 chk("reset", 11'h0C0, {tx_buffer_empty_flag_o, tx_complete_flag_o, rx_full_flag_o,
      overrun_flag_o, noise_flag_o, framing_error_flag_o, tx_data_oe_o, tx_clock_oe_o});
    @(posedge clk_i);
    rstn_i <= 1'b1;
    {tx_clock_polarity_i, last_bit_clock_enable_i, tx_bit8_i, rx_enable_bit_i} <= 4'hF;
    {tx_empty_irq_en_i, tx_complete_irq_en_i, rx_irq_en_i, idle_irq_en_i} <= 4'hF;
    repeat (400) @(posedge clk_i);
    tx_enable_bit_i <= 1'b1;
    #1 chk("idle", 11'h0, idle_flag_o);
    strobe(1, 8'h3C);
    wt(0);
    wt(3);
    repeat (8) @(posedge clk_i);
    for (i = 0; i < 10; i++) begin
      #1 f[i] = tx_data_o;
      chk("clk", i == 0 || i == 9, tx_clock_o);
      repeat (16) @(posedge clk_i);
    end
    chk("frame", {1'b1, 8'h3C, 1'b0}, f);
    wt(1);
    chk("tx irq", 11'h1, tx_irq_o);
    send_break_bit_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    #1 chk("break", 11'h1, {tx_data_o, tx_clock_o});
    send_break_bit_i <= 1'b0;
    wt(1);
    strobe(1, 8'h81);
    wt(0);
    tx_enable_bit_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 chk("oe held", 11'h1, tx_data_oe_o);
    wt(2);
    chk("off", 11'h2, {tx_complete_flag_o, tx_clock_oe_o});
    u_node.send(9'h0A5, 8, 1'b1);
    #1 chk("rx", {3'b101, 8'hA5}, {rx_full_flag_o, noise_flag_o, rx_irq_o, data_rdata_o});
    u_node.send(9'h05A, 8, 1'b1);
    #1 chk("overrun", {1'b1, 8'hA5}, {overrun_flag_o, data_rdata_o});
    strobe(0, 8'h00);
    u_node.send(9'h00F, 8, 1'b0);
    #1 chk("framing", 11'h3, {rx_full_flag_o, framing_error_flag_o});
    // A low stop bit reads as a new start, so that frame must end first.
    repeat (200) @(posedge clk_i);
    strobe(0, 8'h00);
    repeat (200) @(posedge clk_i);
    #1 chk("idle set", 11'h3, {idle_flag_o, rx_irq_o});
    strobe(0, 8'h00);
    word_length_i <= 1'b1;
    u_node.send(9'h133, 9, 1'b1);
    #1 chk("nine", 11'h133, {rx_bit8_o, data_rdata_o});
    word_length_i <= 1'b0;
    strobe(0, 8'h00);
    strobe(2, 8'h00);
    u_node.send(9'h022, 8, 1'b1);
    #1 chk("sleep", 11'h1, {rx_full_flag_o, receiver_sleep_bit_o});
    strobe(3, 8'h00);
    rx_enable_bit_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("rx off", 11'h0, data_rdata_o);
    results;
  end
endmodule // acsi_serial_tb_top
`default_nettype wire
